//--- core/capture_edge_sync.sv
// Purpose: Two-stage synchroniser and edge detector for the capture pin
// Assumes: Pin is asynchronous to core_clk_in
// Notes:   Edges appear two clocks after the pin moves
`timescale 1ns/1ps
module capture_edge_sync
(
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Pin and edges
  input  wire logic pin_in,
  output wire logic rise_out,
  output wire logic fall_out
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Only sync_reg reads the first stage
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise_out = sync_reg & ~prev_reg;
  assign fall_out = ~sync_reg & prev_reg;
endmodule // capture_edge_sync

//--- core/ccp_capture_compare_control.sv
// Purpose: One standard capture/compare unit with PWM duty hold
// Assumes: Timers and PWM generator live outside; port strobes are 1 cycle
// Notes:   Registers, capture path, compare latch and pin driver of one unit
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ccp_capture_compare_control
(
  // Clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  // Register port
  input  wire logic [ccp_pkg::ADDR_W-1:0]    addr_in,
  input  wire logic [ccp_pkg::DATA_W-1:0]    wdata_in,
  input  wire logic                          wr_in,
  input  wire logic                          rd_in,
  output wire logic [ccp_pkg::DATA_W-1:0]    rdata_out,
  // Timers
  input  wire logic [ccp_pkg::WIDE_W-1:0]    first_wide_timer_in,
  input  wire logic [ccp_pkg::WIDE_W-1:0]    second_wide_timer_in,
  input  wire logic [ccp_pkg::PERIOD_W-1:0]  first_period_timer_in,
  input  wire logic [ccp_pkg::PERIOD_W-1:0]  second_period_timer_in,
  output wire logic [ccp_pkg::PERIOD_W-1:0]  period_timer_out,
  output wire logic                          first_timer_reset_out,
  output wire logic                          second_timer_reset_out,
  output wire logic                          adc_start_out,
  // Pin
  input  wire logic                          pin_in,
  input  wire logic                          port_latch_in,
  input  wire logic                          pin_direction_in,
  input  wire logic                          pwm_level_in,
  output wire logic                          pin_out,
  output wire logic                          pin_oe_out,
  // Status and duty
  output wire logic                          unit_event_flag_out,
  output wire logic [ccp_pkg::DUTY_W-1:0]    duty_out
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] vlo_reg;
  logic [7:0] vlo_next;
  logic [7:0] vhi_reg;
  logic [7:0] vhi_next;
  logic       flag_reg;
  logic       flag_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] od_reg;
  logic [7:0] od_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] presc_reg;
  logic [3:0] presc_next;
  logic       latch_reg;
  logic       latch_next;
  logic       match_prev_reg;
  logic       special_reg;
  logic       special_next;

  wire logic rise;
  wire logic fall;

  capture_edge_sync u_sync
  (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .pin_in      (pin_in),
    .rise_out    (rise),
    .fall_out    (fall)
  );

  // Address decode
  wire logic alt_sel = cfg_reg[ccp_pkg::CFG_ALT_SEL_BIT];
  wire logic wr_ctrl = wr_in && (addr_in == ccp_pkg::OFS_CONTROL);
  wire logic wr_vlo  = wr_in && (addr_in == ccp_pkg::OFS_VALUE_LOW);
  wire logic wr_vhi  = wr_in && (addr_in == ccp_pkg::OFS_VALUE_HIGH);
  wire logic wr_flag = wr_in && (addr_in == ccp_pkg::OFS_FLAG);
  wire logic wr_cfg  = wr_in && (addr_in == ccp_pkg::OFS_CONFIG);
  // Shared address: the alias is invisible without alternate select
  wire logic od_seen = (addr_in == ccp_pkg::OFS_OPEN_DRAIN) && alt_sel;
  wire logic wr_od   = wr_in && od_seen;

  // Mode decode
  wire ccp_pkg::mode_t mode     = ccp_pkg::decode_mode(ctrl_reg[3:0]);
  wire ccp_pkg::mode_t new_mode = ccp_pkg::decode_mode(wdata_in[3:0]);
  wire logic is_rise4  = (mode == ccp_pkg::MODE_CAP_RISE4);
  wire logic is_rise16 = (mode == ccp_pkg::MODE_CAP_RISE16);
  wire logic is_capture = (mode == ccp_pkg::MODE_CAP_FALL)
                       || (mode == ccp_pkg::MODE_CAP_RISE)
                       || is_rise4 || is_rise16;
  wire logic is_compare = (mode == ccp_pkg::MODE_CMP_TOGGLE)
                       || (mode == ccp_pkg::MODE_CMP_SET)
                       || (mode == ccp_pkg::MODE_CMP_CLEAR)
                       || (mode == ccp_pkg::MODE_CMP_SOFT)
                       || (mode == ccp_pkg::MODE_CMP_TRIGGER);
  wire logic is_pwm    = (mode == ccp_pkg::MODE_PWM);
  wire logic is_off    = (mode == ccp_pkg::MODE_OFF);

  // Timer routing; a standard unit sees the first pair only on route 00
  wire logic [1:0] route = cfg_reg[ccp_pkg::CFG_ROUTE_MSB:0];
  wire logic use_first = (route == ccp_pkg::ROUTE_ALL_FIRST);
  wire logic [15:0] wide_timer = use_first ? first_wide_timer_in
                                           : second_wide_timer_in;
  wire logic [7:0] period_sel = use_first ? first_period_timer_in
                                          : second_period_timer_in;
  assign period_timer_out = is_pwm ? period_sel : 8'h00;

  // Compare: an edge on equality, so a stopped timer fires once only
  wire logic [15:0] value = {vhi_reg, vlo_reg};
  wire logic cmp_match = is_compare && (wide_timer == value);
  wire logic cmp_event = cmp_match && !match_prev_reg;

  // Capture prescaler
  wire logic presc_hit = (is_rise4 && (presc_reg[1:0] == ccp_pkg::PRESC4_LAST))
                      || (is_rise16 && (presc_reg == ccp_pkg::PRESC16_LAST));
  wire logic cap_event = ((mode == ccp_pkg::MODE_CAP_FALL) && fall)
                      || ((mode == ccp_pkg::MODE_CAP_RISE) && rise)
                      || (rise && presc_hit);
  wire logic presc_step = rise && (is_rise4 || is_rise16);

  // Count survives moves between capture settings only
  assign presc_next = !is_capture ? 4'h0 :
                      presc_step ? 4'(presc_reg + 4'h1) : presc_reg;

  // Registers; a capture outranks a software write to the value bytes
  assign ctrl_next = wr_ctrl ? (wdata_in & ccp_pkg::CTRL_MASK) : ctrl_reg;
  assign vlo_next  = cap_event ? wide_timer[7:0] :
                     wr_vlo ? wdata_in : vlo_reg;
  assign vhi_next  = cap_event ? wide_timer[15:8] :
                     wr_vhi ? wdata_in : vhi_reg;
  assign cfg_next  = wr_cfg ? (wdata_in & ccp_pkg::CFG_MASK) : cfg_reg;
  assign od_next   = wr_od ? (wdata_in & ccp_pkg::OD_MASK) : od_reg;

  // Flag: hardware set wins over a software clear
  wire logic flag_set = cap_event || cmp_event;
  assign flag_next = flag_set ? 1'b1 :
                     wr_flag ? wdata_in[ccp_pkg::FLAG_BIT] : flag_reg;

  // Compare output latch
  wire logic init_low  = wr_ctrl && (new_mode == ccp_pkg::MODE_CMP_SET);
  wire logic init_high = wr_ctrl && (new_mode == ccp_pkg::MODE_CMP_CLEAR);
  assign latch_next =
    init_low  ? 1'b0 :
    init_high ? 1'b1 :
    is_off    ? 1'b0 :
    (cmp_event && mode == ccp_pkg::MODE_CMP_TOGGLE) ? !latch_reg :
    (cmp_event && mode == ccp_pkg::MODE_CMP_SET)    ? 1'b1 :
    (cmp_event && mode == ccp_pkg::MODE_CMP_CLEAR)  ? 1'b0 :
    latch_reg;

  assign special_next = cmp_event && (mode == ccp_pkg::MODE_CMP_TRIGGER);

  // Read mux
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (addr_in)
      ccp_pkg::OFS_CONTROL:    rdata_next = ctrl_reg;
      ccp_pkg::OFS_VALUE_LOW:  rdata_next = vlo_reg;
      ccp_pkg::OFS_VALUE_HIGH: rdata_next = vhi_reg;
      ccp_pkg::OFS_FLAG:       rdata_next = {7'h00, flag_reg};
      ccp_pkg::OFS_CONFIG:     rdata_next = cfg_reg;
      ccp_pkg::OFS_OPEN_DRAIN: rdata_next = alt_sel ? od_reg : 8'h00;
      default:                 rdata_next = 8'h00;
    endcase
    if (!rd_in)
    begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_reg <= ccp_pkg::RST_BYTE;
      vlo_reg  <= ccp_pkg::RST_BYTE;
      vhi_reg  <= ccp_pkg::RST_BYTE;
      cfg_reg  <= ccp_pkg::RST_BYTE;
      od_reg   <= ccp_pkg::RST_BYTE;
      flag_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      vlo_reg  <= vlo_next;
      vhi_reg  <= vhi_next;
      cfg_reg  <= cfg_next;
      od_reg   <= od_next;
      flag_reg <= flag_next;
      rdata_reg <= rdata_next;
    end
  end

  // Internal state, cleared whenever the unit is off
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      presc_reg      <= 4'h0;
      latch_reg      <= 1'b0;
      match_prev_reg <= 1'b0;
      special_reg    <= 1'b0;
    end
    else
    begin
      presc_reg      <= presc_next;
      latch_reg      <= latch_next;
      match_prev_reg <= cmp_match;
      special_reg    <= special_next;
    end
  end

  // Pin driver
  wire logic latch_drives = (mode == ccp_pkg::MODE_CMP_TOGGLE)
                         || (mode == ccp_pkg::MODE_CMP_SET)
                         || (mode == ccp_pkg::MODE_CMP_CLEAR);
  wire logic pin_level = is_pwm ? pwm_level_in :
                         latch_drives ? latch_reg : port_latch_in;
  wire logic od_on = (is_compare || is_pwm) && od_reg[ccp_pkg::OD_BIT];
  assign pin_out    = od_on ? 1'b0 : pin_level;
  assign pin_oe_out = !pin_direction_in && (od_on ? !pin_level : 1'b1);

  assign rdata_out              = rdata_reg;
  assign unit_event_flag_out    = flag_reg;
  assign duty_out               = {vlo_reg, ctrl_reg[ccp_pkg::CTRL_DUTY_ONE_BIT],
                                   ctrl_reg[ccp_pkg::CTRL_DUTY_ZERO_BIT]};
  // Timer pulse goes to the timer the route selected
  assign first_timer_reset_out  = special_reg && use_first;
  assign second_timer_reset_out = special_reg && !use_first;
  assign adc_start_out          = special_reg;

  // Checks
  AST_TOGGLE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cmp_event && mode == ccp_pkg::MODE_CMP_TOGGLE && !wr_ctrl)
    |=> (latch_reg == !$past(latch_reg)) && flag_reg)
    else $error("toggle on match failed");

  AST_FORCE_HIGH: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cmp_event && mode == ccp_pkg::MODE_CMP_SET && !wr_ctrl) |=> latch_reg && flag_reg)
    else $error("force high on match failed");

  AST_FORCE_LOW: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cmp_event && mode == ccp_pkg::MODE_CMP_CLEAR && !wr_ctrl) |=> !latch_reg && flag_reg)
    else $error("force low on match failed");

  AST_INIT_HIGH: assert property (@(posedge core_clk_in) disable iff (rst_in)
    init_high |=> latch_reg)
    else $error("init high failed");

  AST_SOFT_PIN: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (mode == ccp_pkg::MODE_CMP_SOFT && !od_on) |-> pin_out == port_latch_in)
    else $error("soft mode moved the pin");

  AST_TRIGGER: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cmp_event && mode == ccp_pkg::MODE_CMP_TRIGGER)
    |=> adc_start_out && (first_timer_reset_out == use_first) ##1 !adc_start_out)
    else $error("special event pulse wrong");

  AST_CAPTURE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cap_event |=> value == $past(wide_timer) && flag_reg)
    else $error("capture value wrong");

  AST_FLAG_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (flag_reg && !wr_flag) |=> flag_reg)
    else $error("flag dropped without clear");

  AST_PRESC_CLR: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !is_capture |=> presc_reg == 4'h0)
    else $error("prescaler not cleared");

  AST_RISE16: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_rise16 && rise && presc_reg != ccp_pkg::PRESC16_LAST) |-> !cap_event)
    else $error("early capture at 1:16");

  AST_OPEN_DRAIN: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (od_on && pin_level) |-> !pin_oe_out)
    else $error("open drain drove high");

  AST_ROUTE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_pwm && route != ccp_pkg::ROUTE_ALL_FIRST) |-> period_timer_out == second_period_timer_in)
    else $error("route wrong");

  AST_OFF_CLEAR: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_off && !wr_ctrl) |=> !latch_reg && (presc_reg == 4'h0) && !special_reg)
    else $error("off mode kept state");

  AST_VLO_WRITE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (wr_vlo && !cap_event) |=> vlo_reg == $past(wdata_in))
    else $error("low byte write lost");

  AST_VHI_WRITE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (wr_vhi && !cap_event) |=> vhi_reg == $past(wdata_in))
    else $error("high byte write lost");

  AST_FLAG_CLEAR: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (wr_flag && !wdata_in[ccp_pkg::FLAG_BIT] && !flag_set) |=> !flag_reg)
    else $error("flag clear ignored");

  AST_PRESC_KEEP: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_capture && !presc_step) |=> presc_reg == $past(presc_reg))
    else $error("prescaler count lost");

  AST_PRESC_STEP: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_capture && presc_step) |=> presc_reg == 4'($past(presc_reg) + 4'h1))
    else $error("prescaler did not count");

  AST_RISE4: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_rise4 && rise) |-> cap_event == (presc_reg[1:0] == ccp_pkg::PRESC4_LAST))
    else $error("capture at 1:4 off count");

  COV_CAPTURE16: cover property (@(posedge core_clk_in) disable iff (rst_in)
    is_rise16 && cap_event);
  COV_TOGGLE: cover property (@(posedge core_clk_in) disable iff (rst_in)
    cmp_event && mode == ccp_pkg::MODE_CMP_TOGGLE);
  COV_TRIGGER: cover property (@(posedge core_clk_in) disable iff (rst_in)
    special_reg);
  COV_SET_CLEAR: cover property (@(posedge core_clk_in) disable iff (rst_in)
    flag_set && wr_flag);

  COV_CAPTURE4: cover property (@(posedge core_clk_in) disable iff (rst_in)
    is_rise4 && cap_event);
endmodule // ccp_capture_compare_control

//--- core/ccp_pkg.sv
// Purpose: Shared constants and mode decode for the capture/compare unit
// Assumes: 8-bit register port, 16-bit wide timers, 8-bit period timers
// Notes:   Offsets are register indices on the plain port
package ccp_pkg;
  localparam int ADDR_W   = 3;
  localparam int DATA_W   = 8;
  localparam int WIDE_W   = 16;
  localparam int PERIOD_W = 8;
  localparam int DUTY_W   = 10;
  localparam int PRESC_W  = 4;

  localparam logic [2:0] OFS_CONTROL    = 3'h0;
  localparam logic [2:0] OFS_VALUE_LOW  = 3'h1;
  localparam logic [2:0] OFS_VALUE_HIGH = 3'h2;
  localparam logic [2:0] OFS_FLAG       = 3'h3;
  localparam logic [2:0] OFS_CONFIG     = 3'h4;
  localparam logic [2:0] OFS_OPEN_DRAIN = 3'h5;

  localparam int CTRL_DUTY_ONE_BIT  = 5;
  localparam int CTRL_DUTY_ZERO_BIT = 4;
  localparam int CTRL_MODE_MSB      = 3;
  localparam int CFG_ALT_SEL_BIT    = 4;
  localparam int CFG_ROUTE_MSB      = 1;
  localparam int FLAG_BIT           = 0;
  localparam int OD_BIT             = 0;

  localparam logic [7:0] CTRL_MASK  = 8'h3f;
  localparam logic [7:0] CFG_MASK   = 8'h13;
  localparam logic [7:0] OD_MASK    = 8'h01;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] ROUTE_ALL_FIRST = 2'h0;
  localparam logic [1:0] PRESC4_LAST     = 2'h3;
  localparam logic [3:0] PRESC16_LAST    = 4'hf;

  typedef enum logic [3:0] {
    MODE_OFF,
    MODE_RESERVED,
    MODE_CMP_TOGGLE,
    MODE_CAP_FALL,
    MODE_CAP_RISE,
    MODE_CAP_RISE4,
    MODE_CAP_RISE16,
    MODE_CMP_SET,
    MODE_CMP_CLEAR,
    MODE_CMP_SOFT,
    MODE_CMP_TRIGGER,
    MODE_PWM
  } mode_t;

  function automatic mode_t decode_mode(input logic [3:0] code);
    mode_t m;
    m = MODE_OFF;
    unique casez (code)
      4'b0000: m = MODE_OFF;
      4'b0001: m = MODE_RESERVED;
      4'b0010: m = MODE_CMP_TOGGLE;
      4'b0011: m = MODE_RESERVED;
      4'b0100: m = MODE_CAP_FALL;
      4'b0101: m = MODE_CAP_RISE;
      4'b0110: m = MODE_CAP_RISE4;
      4'b0111: m = MODE_CAP_RISE16;
      4'b1000: m = MODE_CMP_SET;
      4'b1001: m = MODE_CMP_CLEAR;
      4'b1010: m = MODE_CMP_SOFT;
      4'b1011: m = MODE_CMP_TRIGGER;
      4'b11??: m = MODE_PWM;
    endcase
    return m;
  endfunction
endpackage

//--- sim/ccp_capture_compare_control_bench.sv
// Purpose: Self-checking bench for the capture/compare unit
// Assumes: Register port with one-cycle strobes, timers from ccp_timer_model
// Notes:   Pin edges are given six clocks to pass the synchroniser
`timescale 1ns/1ps
module ccp_capture_compare_control_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] fw, sw, lval = 16'h0000;
  logic [7:0]  fp, sp, ptim;
  logic        frst, srst, adc, run = 1'b0, load = 1'b0;
  logic        pin = 1'b0, latch = 1'b1, dir = 1'b0, pwm = 1'b0;
  logic        pout, poe, flag;
  logic [9:0]  duty;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          adc_cnt = 0;
  int          frst_cnt = 0;
  int          srst_cnt = 0;
  logic [7:0]  cm [5] = '{8'h08, 8'h09, 8'h02, 8'h0a, 8'h0b};
  logic        pb [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic        pa [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  always #12.5 clk = ~clk;

  ccp_capture_compare_control dut_u (.core_clk_in(clk), .rst_in(rst), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .first_wide_timer_in(fw), .second_wide_timer_in(sw), .first_period_timer_in(fp),
    .second_period_timer_in(sp), .period_timer_out(ptim), .first_timer_reset_out(frst),
    .second_timer_reset_out(srst), .adc_start_out(adc), .pin_in(pin),
    .port_latch_in(latch), .pin_direction_in(dir), .pwm_level_in(pwm), .pin_out(pout),
    .pin_oe_out(poe), .unit_event_flag_out(flag), .duty_out(duty));

  ccp_timer_model timer_u (.core_clk_in(clk), .rst_in(rst), .run_in(run), .load_in(load),
    .load_value_in(lval), .first_reset_in(frst), .second_reset_in(srst),
    .first_wide_out(fw), .second_wide_out(sw), .first_period_out(fp),
    .second_period_out(sp));

  // Pulses are counted so that stray ones in other modes show up too
  always @(posedge clk)
  begin
    adc_cnt  += (adc === 1'b1);
    frst_cnt += (frst === 1'b1);
    srst_cnt += (srst === 1'b1);
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(name, {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic load_timer(input logic [15:0] v);
    @(posedge clk);
    load <= 1'b1;
    lval <= v;
    @(posedge clk);
    load <= 1'b0;
  endtask

  task automatic pin_to(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic rises(input int n);
    repeat (n)
    begin
      pin_to(1'b1);
      pin_to(1'b0);
    end
  endtask

  // Changes the mode, then drops any flag the change raised
  task automatic set_mode(input logic [7:0] c);
    wr_reg(ccp_pkg::OFS_CONTROL, c);
    wr_reg(ccp_pkg::OFS_FLAG, 8'h00);
  endtask

  initial
  begin
    #1ms;
    miscompares++;
    finish_test();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ccp_pkg::OFS_CONTROL, 8'h00, "control reset");
    rd_reg(ccp_pkg::OFS_VALUE_HIGH, 8'h00, "high reset");
    rd_reg(ccp_pkg::OFS_FLAG, 8'h00, "flag reset");
    wr_reg(ccp_pkg::OFS_CONTROL, 8'hff);
    rd_reg(ccp_pkg::OFS_CONTROL, 8'h3f, "control rw");
    wr_reg(3'h6, 8'h5a);
    rd_reg(3'h6, 8'h00, "unmapped");
    // Capture on rising edge, then an unread overwrite
    set_mode(8'h05);
    load_timer(16'h1234);
    pin_to(1'b1);
    rd_reg(ccp_pkg::OFS_VALUE_LOW, 8'h34, "cap low");
    rd_reg(ccp_pkg::OFS_VALUE_HIGH, 8'h12, "cap high");
    rd_reg(ccp_pkg::OFS_FLAG, 8'h01, "cap flag");
    chk("flag out", 16'h0001, {15'h0000, flag});
    load_timer(16'h5678);
    // Pin is still high; a fall first, which this mode ignores
    pin_to(1'b0);
    rises(1);
    rd_reg(ccp_pkg::OFS_VALUE_LOW, 8'h78, "overwrite");
    wr_reg(ccp_pkg::OFS_FLAG, 8'h00);
    rd_reg(ccp_pkg::OFS_FLAG, 8'h00, "flag clear");
    chk("flag out clear", 16'h0000, {15'h0000, flag});
    // Falling edge mode ignores a rise
    set_mode(8'h04);
    load_timer(16'h0abc);
    pin_to(1'b1);
    rd_reg(ccp_pkg::OFS_FLAG, 8'h00, "rise ignored");
    pin_to(1'b0);
    rd_reg(ccp_pkg::OFS_VALUE_LOW, 8'hbc, "fall capture");
    // Prescaler 1:4 from a cleared count
    set_mode(8'h00);
    set_mode(8'h06);
    rises(3);
    rd_reg(ccp_pkg::OFS_FLAG, 8'h00, "third rise");
    rises(1);
    rd_reg(ccp_pkg::OFS_FLAG, 8'h01, "fourth rise");
    // Two edges at 1:4 are kept, so 1:16 fires on its fourteenth edge
    set_mode(8'h00);
    set_mode(8'h06);
    rises(2);
    set_mode(8'h07);
    rises(13);
    rd_reg(ccp_pkg::OFS_FLAG, 8'h00, "kept count 15");
    rises(1);
    rd_reg(ccp_pkg::OFS_FLAG, 8'h01, "kept count 16");
    // Compare modes on entry to equality
    wr_reg(ccp_pkg::OFS_VALUE_LOW, 8'hc8);
    wr_reg(ccp_pkg::OFS_VALUE_HIGH, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      load_timer(16'h00c0);
      set_mode(cm[i]);
      @(negedge clk);
      chk("pin before", {15'h0000, pb[i]}, {15'h0000, pout});
      load_timer(16'h00c8);
      repeat (3) @(negedge clk);
      chk("pin after", {15'h0000, pa[i]}, {15'h0000, pout});
      rd_reg(ccp_pkg::OFS_FLAG, 8'h01, "match flag");
    end
    chk("adc pulses", 16'h0001, adc_cnt[15:0]);
    chk("first reset pulses", 16'h0001, frst_cnt[15:0]);
    chk("second reset pulses", 16'h0000, srst_cnt[15:0]);
    // Open drain only through the alternate select
    wr_reg(ccp_pkg::OFS_OPEN_DRAIN, 8'h01);
    rd_reg(ccp_pkg::OFS_OPEN_DRAIN, 8'h00, "od hidden");
    wr_reg(ccp_pkg::OFS_CONFIG, 8'h10);
    wr_reg(ccp_pkg::OFS_OPEN_DRAIN, 8'h01);
    rd_reg(ccp_pkg::OFS_OPEN_DRAIN, 8'h01, "od visible");
    load_timer(16'h00c0);
    set_mode(8'h08);
    @(negedge clk);
    chk("od low drives", 16'h0001, {14'h0000, pout, poe});
    load_timer(16'h00c8);
    repeat (3) @(negedge clk);
    chk("od high floats", 16'h0000, {14'h0000, pout, poe});
    // Open drain off again, or it would hide the PWM level below
    wr_reg(ccp_pkg::OFS_OPEN_DRAIN, 8'h00);
    @(negedge clk);
    chk("od off drives", 16'h0003, {14'h0000, pout, poe});
    // PWM duty and period timer selection
    wr_reg(ccp_pkg::OFS_CONFIG, 8'h00);
    wr_reg(ccp_pkg::OFS_VALUE_LOW, 8'ha5);
    set_mode(8'h3c);
    pwm <= 1'b1;
    run <= 1'b1;
    repeat (2) @(negedge clk);
    chk("duty", 16'h0297, {6'h00, duty});
    chk("pwm pin", 16'h0001, {15'h0000, pout});
    @(posedge clk);
    dir <= 1'b1;
    @(negedge clk);
    chk("input dir", 16'h0000, {15'h0000, poe});
    chk("period first", {8'h00, fp}, {8'h00, ptim});
    wr_reg(ccp_pkg::OFS_CONFIG, 8'h01);
    repeat (2) @(negedge clk);
    chk("period second", {8'h00, sp}, {8'h00, ptim});
    set_mode(8'h00);
    @(negedge clk);
    chk("off pin", {15'h0000, latch}, {15'h0000, pout});
    // Reserved code idles: pin stays on the port latch, unlike PWM
    set_mode(8'h03);
    latch <= 1'b0;
    rd_reg(ccp_pkg::OFS_CONTROL, 8'h03, "reserved code");
    chk("reserved pin", {15'h0000, latch}, {15'h0000, pout});
    finish_test();
  end
endmodule // ccp_capture_compare_control_bench

//--- sim/ccp_timer_model.sv
// Purpose: Behavioural wide and period timers that sit beside the unit
// Assumes: Bench loads a value; timers count only while run_in is high
// Notes:   Second wide timer holds the inverse of the loaded value
`timescale 1ns/1ps
module ccp_timer_model
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Bench control
  input  wire logic        run_in,
  input  wire logic        load_in,
  input  wire logic [15:0] load_value_in,
  // Special event resets
  input  wire logic        first_reset_in,
  input  wire logic        second_reset_in,
  // Timer values
  output logic      [15:0] first_wide_out,
  output logic      [15:0] second_wide_out,
  output wire logic [7:0]  first_period_out,
  output wire logic [7:0]  second_period_out
);
  assign first_period_out  = first_wide_out[7:0];
  assign second_period_out = second_wide_out[7:0];

  // Counting only on the core clock keeps capture and compare exact
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      first_wide_out  <= 16'h0000;
      second_wide_out <= 16'h0000;
    end
    else if (load_in)
    begin
      first_wide_out  <= load_value_in;
      second_wide_out <= ~load_value_in;
    end
    else
    begin
      first_wide_out  <= first_reset_in ? 16'h0000 : first_wide_out + {15'h0000, run_in};
      second_wide_out <= second_reset_in ? 16'h0000 : second_wide_out + {15'h0000, run_in};
    end
  end
endmodule // ccp_timer_model
